// file: hdl/pott_trip.sv
// permissive over-reaching transfer trip: keying, receive shaping, echo, seal-in
// assumes field inputs are asynchronous pins; settings are static same-clock levels
//
// Function
// - with echo enabled, echo qualified receive only while line end open validated
// - echo is a one-shot, then locked out for the echo lockout time
// - echo pulse lasts the echo duration regardless of receive shape
// - receive accepted only after staying high for the receive qualify delay
// - receive joins ground forward indication only inside the transient pass window
// - ground-path receive ends when the pass window from transmit pickup expires
// - after the window the ground path is blocked for the transient block time
// - transient blocking gates only the ground path, never the zone path
// - line end open must persist for its pickup delay before echo allowed
// - operate is stretched to last at least the minimum pulse time
// - assigned ground forward indication keys transmit and starts operation with zone
// - every timer is set from 0 to 65.535 s in 1 ms steps
// - scheme disabled means no transmit, echo or operate
`timescale 1ns/1ps
module pott_trip import pott_pkg::*; #(
    parameter int CYC_PER_MS = MS_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic scheme_enable,
    input wire logic echo_enable,
    input wire logic ground_forward_assigned,
    input wire logic overreach_zone_pickup,
    input wire logic ground_forward_direction,
    input wire logic permissive_receive,
    input wire logic line_end_open_detect,
    input wire logic [SET_W-1:0] receive_qualify_delay,
    input wire logic [SET_W-1:0] transient_pass_window,
    input wire logic [SET_W-1:0] transient_block_time,
    input wire logic [SET_W-1:0] echo_duration,
    input wire logic [SET_W-1:0] echo_lockout,
    input wire logic [SET_W-1:0] line_end_open_delay,
    input wire logic [SET_W-1:0] operate_min_pulse,
    output logic permissive_transmit,
    output logic scheme_operate,
    output logic echo_active,
    output logic ground_path_blocked
);
    logic [1:0] zone_s, gnd_s, rx_s, leo_s;
    logic key, key_d, rx_q, leo_ok, gnd_path, op_raw, seal;
    pott_tr_e tr_st;
    pott_echo_e ec_st;
    pott_tmr_if tmr[T_NUM] ();

    function automatic logic [31:0] ms_to_cyc(input logic [SET_W-1:0] ms);
        ms_to_cyc = 32'(ms) * 32'(CYC_PER_MS);
    endfunction : ms_to_cyc

    // =========================================
    // pin synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            zone_s <= 2'h0;
            gnd_s <= 2'h0;
            rx_s <= 2'h0;
            leo_s <= 2'h0;
        end else if (clock_enable) begin
            zone_s <= {zone_s[0], overreach_zone_pickup};
            gnd_s <= {gnd_s[0], ground_forward_direction};
            rx_s <= {rx_s[0], permissive_receive};
            leo_s <= {leo_s[0], line_end_open_detect};
        end
    end

    // =========================================
    // timers
    for (genvar i = 0; i < T_NUM; i++) begin : g_tmr
        pott_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
            .clock(clock),
            .reset_n(reset_n),
            .t(tmr[i])
        );
        assign tmr[i].run = clock_enable;
    end
    assign tmr[T_RXQ].arm = rx_s[1];
    assign tmr[T_RXQ].setting = receive_qualify_delay;
    assign tmr[T_LEO].arm = leo_s[1];
    assign tmr[T_LEO].setting = line_end_open_delay;
    assign tmr[T_PASS].arm = (tr_st == TR_PASS);
    assign tmr[T_PASS].setting = transient_pass_window;
    assign tmr[T_BLOCK].arm = (tr_st == TR_BLOCK);
    assign tmr[T_BLOCK].setting = transient_block_time;
    assign tmr[T_ECHO].arm = (ec_st == EC_SEND);
    assign tmr[T_ECHO].setting = echo_duration;
    assign tmr[T_ELOCK].arm = (ec_st == EC_LOCK);
    assign tmr[T_ELOCK].setting = echo_lockout;
    assign tmr[T_SEAL].arm = seal;
    assign tmr[T_SEAL].setting = operate_min_pulse;

    assign rx_q = tmr[T_RXQ].done;
    assign leo_ok = tmr[T_LEO].done;
    assign key = zone_s[1] | (ground_forward_assigned & gnd_s[1]);
    // only the ground term is window-gated; zone keeps full security on its own
    assign gnd_path = ground_forward_assigned & gnd_s[1] & rx_q & (tr_st == TR_PASS);
    assign op_raw = scheme_enable & rx_q & (zone_s[1] | gnd_path);

    // =========================================
    // transient blocking of the ground path
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            key_d <= 1'b0;
            tr_st <= TR_IDLE;
        end else if (clock_enable) begin
            key_d <= key;
            unique case (tr_st)
                TR_IDLE: begin
                    if (key && !key_d) begin
                        tr_st <= TR_PASS;
                    end
                end
                TR_PASS: begin
                    if (tmr[T_PASS].done) begin
                        tr_st <= TR_BLOCK;
                    end
                end
                TR_BLOCK: begin
                    if (tmr[T_BLOCK].done) begin
                        tr_st <= TR_IDLE;
                    end
                end
                default: begin
                    tr_st <= TR_IDLE;
                end
            endcase
        end
    end

    // =========================================
    // echo one-shot
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ec_st <= EC_IDLE;
        end else if (clock_enable) begin
            unique case (ec_st)
                EC_IDLE: begin
                    if (scheme_enable && echo_enable && rx_q && leo_ok) begin
                        ec_st <= EC_SEND;
                    end
                end
                EC_SEND: begin
                    if (tmr[T_ECHO].done) begin
                        ec_st <= EC_LOCK;
                    end
                end
                EC_LOCK: begin
                    if (tmr[T_ELOCK].done) begin
                        ec_st <= EC_IDLE;
                    end
                end
                default: begin
                    ec_st <= EC_IDLE;
                end
            endcase
        end
    end

    // =========================================
    // seal-in and outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            seal <= 1'b0;
            permissive_transmit <= 1'b0;
            scheme_operate <= 1'b0;
            echo_active <= 1'b0;
            ground_path_blocked <= 1'b0;
        end else if (clock_enable) begin
            if (tmr[T_SEAL].done || !scheme_enable) begin
                seal <= 1'b0;
            end else if (op_raw) begin
                seal <= 1'b1;
            end
            // a noisy channel can chop op_raw; seal keeps the trip whole
            scheme_operate <= scheme_enable & (op_raw | seal);
            permissive_transmit <= scheme_enable & (key | (ec_st == EC_SEND));
            echo_active <= scheme_enable & (ec_st == EC_SEND);
            ground_path_blocked <= (tr_st == TR_BLOCK);
        end
    end

    // =========================================
    // checks
    logic [31:0] echo_len, op_len;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            echo_len <= '0;
            op_len <= '0;
        end else if (clock_enable) begin
            echo_len <= (ec_st == EC_SEND) ? echo_len + 32'h00000001 : 32'h00000000;
            op_len <= scheme_operate ? op_len + 32'h00000001 : 32'h00000000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    disabled_quiet_a: assert property (clock_enable && !scheme_enable |=>
        !permissive_transmit && !scheme_operate && !echo_active)
        else $error("output active while scheme disabled");
    tx_or_a: assert property (clock_enable && scheme_enable && (key || ec_st == EC_SEND)
        |=> permissive_transmit)
        else $error("transmit missing for its cause");
    gnd_key_a: assert property (clock_enable && scheme_enable && ground_forward_assigned
        && gnd_s[1] |=> permissive_transmit)
        else $error("ground forward did not key transmit");
    echo_cause_a: assert property ($rose(ec_st == EC_SEND) |->
        $past(echo_enable && rx_q && leo_ok && scheme_enable))
        else $error("echo started without its conditions");
    echo_lockout_a: assert property (ec_st == EC_SEND && tmr[T_ECHO].done && clock_enable
        |=> ec_st == EC_LOCK)
        else $error("echo not followed by lockout");
    echo_len_a: assert property (ec_st == EC_SEND && tmr[T_ECHO].done && clock_enable |->
        echo_len == ms_to_cyc(echo_duration) + 32'h00000001)
        else $error("echo pulse length wrong");
    rx_qual_a: assert property (rx_q |-> $past(rx_s[1]))
        else $error("receive qualified without input");
    gnd_window_a: assert property (clock_enable && scheme_enable && ground_forward_assigned && gnd_s[1]
        && rx_q && tr_st == TR_PASS |=> scheme_operate)
        else $error("ground path missing inside window");
    window_end_a: assert property (tr_st == TR_PASS && tmr[T_PASS].done && clock_enable
        |=> tr_st == TR_BLOCK)
        else $error("pass window did not close");
    block_quiet_a: assert property (clock_enable && ground_path_blocked && !zone_s[1] && !seal
        |=> !scheme_operate)
        else $error("ground path active while blocked");
    zone_free_a: assert property (clock_enable && scheme_enable && rx_q && zone_s[1]
        |=> scheme_operate)
        else $error("zone path blocked");
    seal_min_a: assert property ($fell(scheme_operate) && $past(scheme_enable) |->
        $past(op_len) >= ms_to_cyc(operate_min_pulse))
        else $error("operate pulse too short");
    op_cause_a: assert property (clock_enable && op_raw |=> scheme_operate)
        else $error("operate missing");

    echo_sent_c: cover property ($rose(ec_st == EC_SEND));
    gnd_trip_c: cover property (gnd_path && op_raw);
    block_c: cover property ($rose(tr_st == TR_BLOCK));
    seal_c: cover property (scheme_operate && !op_raw);
endmodule : pott_trip

// file: hdl/pott_pkg.sv
// package for the permissive over-reaching trip logic
// assumes one 125 MHz clock; all settings are in milliseconds
package pott_pkg;
    // =========================================
    // timebase
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int SET_W = 16;
    localparam int SYNC_RESET = 0;

    // =========================================
    // timer slots
    localparam int T_RXQ = 0;
    localparam int T_LEO = 1;
    localparam int T_PASS = 2;
    localparam int T_BLOCK = 3;
    localparam int T_ECHO = 4;
    localparam int T_ELOCK = 5;
    localparam int T_SEAL = 6;
    localparam int T_NUM = 7;

    // =========================================
    // state machines
    typedef enum logic [1:0] {
        TR_IDLE = 2'b00,
        TR_PASS = 2'b01,
        TR_BLOCK = 2'b10
    } pott_tr_e;

    typedef enum logic [1:0] {
        EC_IDLE = 2'b00,
        EC_SEND = 2'b01,
        EC_LOCK = 2'b10
    } pott_echo_e;
endpackage : pott_pkg

// file: hdl/pott_tmr_if.sv
// carrier between the trip logic and its millisecond timers
// assumes all signals on the one system clock
`timescale 1ns/1ps
interface pott_tmr_if;
    import pott_pkg::*;
    logic run;
    logic arm;
    logic [SET_W-1:0] setting;
    logic done;
    modport ctrl (output run, output arm, output setting, input done);
    modport tmr (input run, input arm, input setting, output done);
endinterface : pott_tmr_if

// file: hdl/pott_timer.sv
// millisecond pickup timer: done rises once arm has stayed high for setting ms
// assumes arm is a same-clock level; run is the shared clock enable
`timescale 1ns/1ps
module pott_timer import pott_pkg::*; #(
    parameter int CYC_PER_MS = MS_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    pott_tmr_if.tmr t
);
    logic [31:0] cyc;
    logic [SET_W-1:0] elapsed;

    // =========================================
    // counting, restarted whenever arm drops so each interval is exact
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cyc <= '0;
            elapsed <= '0;
            t.done <= 1'b0;
        end else if (t.run) begin
            if (!t.arm) begin
                cyc <= '0;
                elapsed <= '0;
                t.done <= 1'b0;
            end else begin
                t.done <= (elapsed >= t.setting);
                if (cyc == 32'(CYC_PER_MS - 1)) begin
                    cyc <= '0;
                    // saturate so a long arm never wraps back to zero
                    if (elapsed != {SET_W{1'b1}}) begin
                        elapsed <= elapsed + 16'h0001;
                    end
                end else begin
                    cyc <= cyc + 32'h00000001;
                end
            end
        end
    end
endmodule : pott_timer

// file: tb/pott_remote.sv
// remote line-end relay model: drives the permissive receive pin
// assumes the bench asks for a keyed level or a short burst, on the system clock
`timescale 1ns/1ps
module pott_remote (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic send,
    input wire logic [7:0] burst,
    output logic permissive_receive
);
    logic [7:0] left;
    // a burst loads on the edge where it is nonzero; the bench holds it for one edge only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            left <= 8'h00;
        end else if (burst != 8'h00) begin
            left <= burst;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // a contact output: released means open, which the input reads as low
    assign permissive_receive = send | (left != 8'h00);
endmodule : pott_remote

// file: tb/test_pott_trip.sv
// self-checking bench for the permissive over-reaching trip logic
// assumes a 125 MHz clock and a shortened millisecond of 4 cycles
`timescale 1ns/1ps
module test_pott_trip;
    import pott_pkg::*;
    localparam int CPM = 4;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic scheme_enable = 1'b1, echo_enable = 1'b0, gfa = 1'b0, zone = 1'b0, gfd = 1'b0, leo = 1'b0, send = 1'b0;
    logic [7:0] burst = 8'h00;
    logic [SET_W-1:0] op_min = 16'h0005;
    logic ce = 1'b1;
    logic [SET_W-1:0] rx_dly = 16'h0002;
    logic permissive_transmit, scheme_operate, echo_active, ground_path_blocked, rx;
    int n_errors = 0;
    int n_tests = 0;
    int h_tx, h_op, h_ec, h_bl;

    initial begin
        forever #4 clock = ~clock;
    end

    pott_remote u_remote (.clock(clock), .reset_n(reset_n), .send(send), .burst(burst), .permissive_receive(rx));

    pott_trip #(.CYC_PER_MS(CPM)) u_dut (.clock(clock), .reset_n(reset_n), .clock_enable(ce),
        .scheme_enable(scheme_enable), .echo_enable(echo_enable), .ground_forward_assigned(gfa),
        .overreach_zone_pickup(zone), .ground_forward_direction(gfd), .permissive_receive(rx),
        .line_end_open_detect(leo), .receive_qualify_delay(rx_dly), .transient_pass_window(16'h0003),
        .transient_block_time(16'h0005), .echo_duration(16'h0002), .echo_lockout(16'h000A),
        .line_end_open_delay(16'h0006), .operate_min_pulse(op_min), .permissive_transmit(permissive_transmit),
        .scheme_operate(scheme_operate), .echo_active(echo_active), .ground_path_blocked(ground_path_blocked));

    // ========================================
    // checks and helpers
    task automatic summarize();
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: level %b, expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_cnt(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("CHECK FAILED at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : check_cnt

    // counts the cycles in which each output is high over n edges
    task automatic watch(input int n);
        h_tx = 0;
        h_op = 0;
        h_ec = 0;
        h_bl = 0;
        repeat (n) begin
            @(negedge clock);
            h_tx += (permissive_transmit === 1'b1);
            h_op += (scheme_operate === 1'b1);
            h_ec += (echo_active === 1'b1);
            h_bl += (ground_path_blocked === 1'b1);
        end
        // return on a rising edge so the caller's next drive lands on it
        @(posedge clock);
    endtask : watch

    // ========================================
    // scenarios
    task automatic sc_disabled();
        @(posedge clock);
        scheme_enable <= 1'b0;
        zone <= 1'b1;
        send <= 1'b1;
        watch(30);
        check_cnt(h_tx + h_op, 0, 0);
        zone <= 1'b0;
        send <= 1'b0;
        scheme_enable <= 1'b1;
        watch(60);
    endtask : sc_disabled

    task automatic sc_zone();
        int ops;
        @(posedge clock);
        zone <= 1'b1;
        burst <= 8'h05;
        @(posedge clock);
        burst <= 8'h00;
        watch(30);
        check_cnt(h_tx, 25, 30);
        check_cnt(h_op, 0, 0);
        send <= 1'b1;
        watch(14);
        ops = h_op;
        send <= 1'b0;
        zone <= 1'b0;
        watch(60);
        // seal-in of 5 ms is 20 cycles; the cause lasted only a few
        check_cnt(ops + h_op, 20, 40);
    endtask : sc_zone

    task automatic sc_ground();
        int ops;
        ops = 0;
        op_min <= 16'h0001;
        gfa <= 1'b1;
        gfd <= 1'b1;
        send <= 1'b1;
        watch(6);
        check_cnt(h_tx, 2, 6);
        for (int i = 0; i < 60 && h_bl == 0; i++) begin
            watch(1);
            ops += h_op;
        end
        check_bit(h_bl != 0, 1'b1);
        check_cnt(ops, 1, 60);
        // let the short seal-in of the window's operate run out first
        watch(4);
        watch(8);
        check_cnt(h_op, 0, 0);
        check_cnt(h_bl, 8, 8);
        zone <= 1'b1;
        watch(6);
        check_cnt(h_op, 1, 6);
        zone <= 1'b0;
        gfd <= 1'b0;
        send <= 1'b0;
        gfa <= 1'b0;
        op_min <= 16'h0005;
        watch(60);
    endtask : sc_ground

    task automatic sc_echo();
        int ec;
        int tx;
        leo <= 1'b1;
        echo_enable <= 1'b1;
        watch(30);
        send <= 1'b1;
        watch(40);
        ec = h_ec;
        tx = h_tx;
        send <= 1'b0;
        watch(2);
        check_cnt(ec, 10, 10);
        check_cnt(tx, 10, 10);
        send <= 1'b1;
        watch(15);
        ec = h_ec;
        send <= 1'b0;
        watch(40);
        check_cnt(ec + h_ec, 0, 0);
        leo <= 1'b0;
        watch(30);
        // receive qualifies before line end open has been validated
        leo <= 1'b1;
        send <= 1'b1;
        watch(16);
        ec = h_ec;
        send <= 1'b0;
        watch(20);
        check_cnt(ec + h_ec, 0, 0);
        leo <= 1'b0;
        echo_enable <= 1'b0;
        watch(40);
    endtask : sc_echo

    // a frozen block holds outputs and timers; the seal-in resumes rather than restarts
    task automatic sc_freeze();
        rx_dly <= 16'h0000;
        zone <= 1'b1;
        send <= 1'b1;
        watch(20);
        check_cnt(h_op, 15, 16);
        ce <= 1'b0;
        zone <= 1'b0;
        send <= 1'b0;
        watch(30);
        check_cnt(h_op + h_tx, 60, 60);
        ce <= 1'b1;
        watch(40);
        check_cnt(h_op, 5, 9);
        rx_dly <= 16'h0002;
    endtask : sc_freeze

    // ========================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        #1;
        check_bit(permissive_transmit | scheme_operate | echo_active | ground_path_blocked, 1'b0);
        sc_disabled();
        sc_zone();
        sc_ground();
        sc_echo();
        sc_freeze();
        summarize();
    end
endmodule : test_pott_trip
